// *** logic/btc_calendar.sv ***
// Time and calendar counter chain with host register port
`timescale 1ns/1ps
module btc_calendar
    import btc_pkg::*;
#(
    parameter int OSC_DIV = CLK_HZ / OSC_HZ,
    parameter int SEC_DIV = OSC_HZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic osc_en,
    input wire logic host_busy,
    input wire btc_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    output btc_time_t time_out,
    output logic update_event
);
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic srst_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign srst_n = rst_s2_ff;

    // Oscillator enable into a 32768 Hz rate pulse, then 1 Hz
    logic osc_pulse;
    logic sec_tick;
    logic osc_src;
    assign osc_src = (OSC_DIV <= 1) ? 1'b1 : osc_en;
    btc_divider #(.DIV(OSC_DIV)) u_osc_div (
        .clk(clk),
        .rst_n(srst_n),
        .en_in(osc_src),
        .pulse(osc_pulse)
    );
    btc_divider #(.DIV(SEC_DIV)) u_sec_div (
        .clk(clk),
        .rst_n(srst_n),
        .en_in(osc_pulse),
        .pulse(sec_tick)
    );

    btc_time_t t_ff;
    btc_time_t nxt_t;
    logic [7:0] ext_ff;
    logic [7:0] nxt_ext;
    logic pend_ff;
    logic nxt_pend;
    logic upd_ff;
    logic nxt_upd;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    logic [7:0] sec_n, min_n, hour_n, date_n, month_n, year_n;
    logic sec_w, min_w, hour_w, date_w, month_w, year_w;
    logic [7:0] date_last;
    logic leap;
    logic [4:0] loc;
    logic hold;

    // BCD value divisible by 4: even tens need units 0, 4, 8; odd tens 2, 6
    always_comb begin
        if (t_ff.year[4]) begin
            leap = (t_ff.year[3:0] == 4'h2) || (t_ff.year[3:0] == 4'h6);
        end else begin
            leap = (t_ff.year[3:0] == 4'h0) || (t_ff.year[3:0] == 4'h4)
                || (t_ff.year[3:0] == 4'h8);
        end
    end

    always_comb begin
        if (t_ff.month == MON_FEB) begin
            date_last = leap ? DAYS_29 : DAYS_28;
        end else if (t_ff.month == MON_APR || t_ff.month == MON_JUN
                || t_ff.month == MON_SEP || t_ff.month == MON_NOV) begin
            date_last = DAYS_30;
        end else begin
            date_last = DAYS_31;
        end
    end

    btc_bcd_step u_sec (.cur(t_ff.sec), .last(MAX_SEC), .first(ZERO_BCD),
        .next(sec_n), .wrap(sec_w));
    btc_bcd_step u_min (.cur(t_ff.min), .last(MAX_MIN), .first(ZERO_BCD),
        .next(min_n), .wrap(min_w));
    btc_bcd_step u_hour (.cur(t_ff.hour), .last(MAX_HOUR), .first(ZERO_BCD),
        .next(hour_n), .wrap(hour_w));
    btc_bcd_step u_date (.cur(t_ff.date), .last(date_last), .first(ONE_BCD),
        .next(date_n), .wrap(date_w));
    btc_bcd_step u_month (.cur(t_ff.month), .last(MAX_MONTH), .first(ONE_BCD),
        .next(month_n), .wrap(month_w));
    btc_bcd_step u_year (.cur(t_ff.year), .last(MAX_YEAR), .first(ZERO_BCD),
        .next(year_n), .wrap(year_w));

    // Both base and mirror windows map to the same storage
    assign loc = req.addr & ~ADDR_MIRROR_BIT;
    assign hold = host_busy || req.wr || req.rd;

    always_comb begin
        nxt_t = t_ff;
        nxt_ext = ext_ff;
        nxt_pend = pend_ff;
        nxt_upd = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_rvalid = 1'b0;
        // A tick during an access is kept and applied once the access ends
        if (sec_tick) begin
            nxt_pend = 1'b1;
        end
        if (!hold && (pend_ff || sec_tick)) begin
            // A fresh tick meeting a pending one stays pending, so none is lost
            nxt_pend = pend_ff && sec_tick;
            nxt_t.sec = sec_n;
            nxt_upd = !ext_ff[UPDATE_EVENT_SELECT_BIT] || sec_w;
            if (sec_w) begin
                nxt_t.min = min_n;
                if (min_w) begin
                    nxt_t.hour = hour_n;
                    if (hour_w) begin
                        nxt_t.week = (t_ff.week == WEEK_SAT) ? WEEK_SUN
                            : {t_ff.week[6:0], 1'b0} & MASK_WEEK;
                        nxt_t.date = date_n;
                        if (date_w) begin
                            nxt_t.month = month_n;
                            if (month_w) begin
                                nxt_t.year = year_n;
                            end
                        end
                    end
                end
            end
        end
        if (req.wr) begin
            unique case (loc)
                ADDR_SEC: nxt_t.sec = req.wdata & MASK_SEC;
                ADDR_MIN: nxt_t.min = req.wdata & MASK_MIN;
                ADDR_HOUR: nxt_t.hour = req.wdata & MASK_HOUR;
                ADDR_WEEK: nxt_t.week = req.wdata & MASK_WEEK;
                ADDR_DATE: nxt_t.date = req.wdata & MASK_DATE;
                ADDR_MONTH: nxt_t.month = req.wdata & MASK_MONTH;
                ADDR_YEAR: nxt_t.year = req.wdata & MASK_YEAR;
                ADDR_EXT: nxt_ext = req.wdata;
                default: nxt_ext = ext_ff;
            endcase
        end
        if (req.rd) begin
            nxt_rvalid = 1'b1;
            unique case (loc)
                ADDR_SEC: nxt_rdata = t_ff.sec & MASK_SEC;
                ADDR_MIN: nxt_rdata = t_ff.min & MASK_MIN;
                ADDR_HOUR: nxt_rdata = t_ff.hour & MASK_HOUR;
                ADDR_WEEK: nxt_rdata = t_ff.week & MASK_WEEK;
                ADDR_DATE: nxt_rdata = t_ff.date & MASK_DATE;
                ADDR_MONTH: nxt_rdata = t_ff.month & MASK_MONTH;
                ADDR_YEAR: nxt_rdata = t_ff.year;
                ADDR_EXT: nxt_rdata = ext_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            t_ff <= {RST_SEC, RST_MIN, RST_HOUR, RST_WEEK, RST_DATE, RST_MONTH, RST_YEAR};
            ext_ff <= RST_EXT;
            pend_ff <= 1'b0;
            upd_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            t_ff <= nxt_t;
            ext_ff <= nxt_ext;
            pend_ff <= nxt_pend;
            upd_ff <= nxt_upd;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign rdata = rdata_ff;
    assign rvalid = rvalid_ff;
    assign time_out = t_ff;
    assign update_event = upd_ff;
endmodule

// *** logic/btc_pkg.sv ***
// Package with constants and types for the BCD time and calendar counter
// Summary of operation
// - Update event per second, or minute when selected
// - Seconds packed BCD, tens bits 6-4
// - Seconds count 00 to 59, then 00
// - Minutes count 00 to 59, then 00
// - Hours count 00 to 23, then 00
// - Fixed-zero bits ignore writes, read zero
// - Weekday one-hot, shifts left, Saturday to Sunday
// - Calendar correct 2001-2099, 2100 treated leap
// - Date packed BCD, tens bits 5-4
// - Date wraps at 31 or 30 per month
// - February wraps at 28, or 29 leap
// - Year divisible by four is leap
// - Month counts 01 to 12, then 01
// - Year full BCD 00 to 99 wrapping
// - Registers aliased at base and mirror
// - Counting held during host access
package btc_pkg;
    localparam logic [4:0] ADDR_SEC = 5'h00;
    localparam logic [4:0] ADDR_MIN = 5'h01;
    localparam logic [4:0] ADDR_HOUR = 5'h02;
    localparam logic [4:0] ADDR_WEEK = 5'h03;
    localparam logic [4:0] ADDR_DATE = 5'h04;
    localparam logic [4:0] ADDR_MONTH = 5'h05;
    localparam logic [4:0] ADDR_YEAR = 5'h06;
    localparam logic [4:0] ADDR_EXT = 5'h0d;
    localparam logic [4:0] ADDR_MIRROR_BIT = 5'h10;
    localparam int UPDATE_EVENT_SELECT_BIT = 5;
    localparam logic [7:0] MASK_SEC = 8'h7f;
    localparam logic [7:0] MASK_MIN = 8'h7f;
    localparam logic [7:0] MASK_HOUR = 8'h3f;
    localparam logic [7:0] MASK_WEEK = 8'h7f;
    localparam logic [7:0] MASK_DATE = 8'h3f;
    localparam logic [7:0] MASK_MONTH = 8'h1f;
    localparam logic [7:0] MASK_YEAR = 8'hff;
    localparam logic [7:0] MAX_SEC = 8'h59;
    localparam logic [7:0] MAX_MIN = 8'h59;
    localparam logic [7:0] MAX_HOUR = 8'h23;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    localparam logic [7:0] ZERO_BCD = 8'h00;
    localparam logic [7:0] ONE_BCD = 8'h01;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic [7:0] WEEK_SUN = 8'h01;
    localparam logic [7:0] WEEK_SAT = 8'h40;
    localparam logic [7:0] RST_SEC = 8'h00;
    localparam logic [7:0] RST_MIN = 8'h00;
    localparam logic [7:0] RST_HOUR = 8'h00;
    localparam logic [7:0] RST_WEEK = 8'h01;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h01;
    localparam logic [7:0] RST_EXT = 8'h00;
    localparam int OSC_HZ = 32768;
    localparam int CLK_HZ = 125000000;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] week;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } btc_time_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } btc_req_t;
endpackage

// *** logic/btc_divider.sv ***
// Pulse divider producing a one-cycle enable every DIV input enables
`timescale 1ns/1ps
module btc_divider
    import btc_pkg::*;
#(
    parameter int DIV = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en_in,
    output logic pulse
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic pulse_ff;
    logic nxt_pulse;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_pulse = 1'b0;
        if (en_in) begin
            if (cnt_ff == LAST) begin
                nxt_cnt = '0;
                nxt_pulse = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            pulse_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse = pulse_ff;
endmodule

// *** logic/btc_bcd_step.sv ***
// Combinational BCD increment with wrap to a given start value
`timescale 1ns/1ps
module btc_bcd_step
    import btc_pkg::*;
(
    input wire logic [7:0] cur,
    input wire logic [7:0] last,
    input wire logic [7:0] first,
    output logic [7:0] next,
    output logic wrap
);
    always_comb begin
        wrap = (cur == last);
        if (wrap) begin
            next = first;
        end else if (cur[3:0] == 4'h9) begin
            next = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            next = {cur[7:4], cur[3:0] + 4'h1};
        end
    end
endmodule

// *** testbench/btc_calendar_sva.sv ***
// Checker for the calendar counter ports
`timescale 1ns/1ps
module btc_calendar_sva
    import btc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_busy,
    input wire btc_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire btc_time_t time_out,
    input wire logic update_event
);
    logic upd_sel_ff;
    logic nxt_upd_sel;
    always_comb begin
        nxt_upd_sel = upd_sel_ff;
        if (req.wr && req.addr[3:0] == ADDR_EXT[3:0]) begin
            nxt_upd_sel = req.wdata[UPDATE_EVENT_SELECT_BIT];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_sel_ff <= 1'b0;
        end else begin
            upd_sel_ff <= nxt_upd_sel;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_sec_wrap: assert property ((!req.wr && time_out.sec == 8'h59 ##1 time_out.sec != 8'h59)
        |-> time_out.sec == 8'h00 && time_out.min != $past(time_out.min)) else $error("sec wrap");
    a_hour_wrap: assert property ((!req.wr && time_out[55:32] == 24'h595923
        ##1 time_out.sec != 8'h59) |-> time_out.hour == 8'h00 && $changed(time_out.date))
        else $error("hour wrap");
    a_week_shift: assert property ((!req.wr ##1 $changed(time_out.week))
        |-> time_out.week == (($past(time_out.week) == 8'h40) ? 8'h01
        : {$past(time_out.week[6:0]), 1'b0})) else $error("week shift");
    a_zero_bits: assert property (((time_out.sec & ~MASK_SEC) | (time_out.hour & ~MASK_HOUR)
        | (time_out.date & ~MASK_DATE) | (time_out.month & ~MASK_MONTH)) == 8'h00)
        else $error("fixed bits");
    a_zero_high: assert property (((time_out.min & ~MASK_MIN) | (time_out.week & ~MASK_WEEK))
        == 8'h00) else $error("fixed high bits");
    a_hold_busy: assert property ((host_busy && !req.wr) |=> $stable(time_out.sec))
        else $error("count in access");
    a_upd_sec: assert property ((update_event && !upd_sel_ff) |-> $changed(time_out.sec))
        else $error("second event");
    a_upd_min: assert property ((update_event && upd_sel_ff) |-> time_out.sec == 8'h00)
        else $error("minute event");
    a_adv_event: assert property ((!req.wr ##1 $changed(time_out.sec) && !upd_sel_ff)
        |-> update_event) else $error("missing event");
    a_read_ans: assert property (req.rd |=> rvalid) else $error("read answer");
    a_read_quiet: assert property (!req.rd |=> !rvalid) else $error("stray answer");
    a_read_sec: assert property ((req.rd && req.addr[3:0] == 4'h0)
        |=> rdata == $past(time_out.sec)) else $error("sec read");
endmodule
bind btc_calendar btc_calendar_sva chk (.clk(clk), .rst_n(rst_n), .host_busy(host_busy),
    .req(req), .rdata(rdata), .rvalid(rvalid), .time_out(time_out),
    .update_event(update_event));

// *** testbench/btc_host_model.sv ***
// Host controller model issuing register accesses
`timescale 1ns/1ps
module btc_host_model
    import btc_pkg::*;
(
    input wire logic clk,
    output btc_req_t req,
    output logic host_busy
);
    initial begin
        req = '0;
        host_busy = 1'b0;
    end
    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        host_busy <= 1'b1;
        req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic idle();
        @(posedge clk);
        host_busy <= 1'b0;
    endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the calendar counter
`timescale 1ns/1ps
module tb_top
    import btc_pkg::*;
;
    `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
        $display("Error %s exp %h got %h", nm, e, g); end end
    logic clk, rst_n, rvalid, update_event, host_busy, upd_sel;
    logic [7:0] rdata, wbyte;
    logic [31:0] seed = 32'h02cb151b;
    btc_req_t req;
    btc_time_t time_out, row, exp;
    int n_mismatch = 0, n_compared = 0, j;
    btc_time_t rows [8] = '{56'h58592340311299, 56'h59592302280204, 56'h59592302280203,
        56'h59592304290200, 56'h59592308300412, 56'h59592310300115, 56'h00592320310898,
        56'h00592301300611};
    btc_calendar #(.OSC_DIV(1), .SEC_DIV(4)) uut (.clk(clk), .rst_n(rst_n), .osc_en(1'b1),
        .host_busy(host_busy), .req(req), .rdata(rdata), .rvalid(rvalid),
        .time_out(time_out), .update_event(update_event));
    btc_host_model host (.clk(clk), .req(req), .host_busy(host_busy));
    always #4 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] mir();
        logic [31:0] r;
        r = xs();
        return r[0] ? 5'h10 : 5'h00;
    endfunction
    function automatic logic [7:0] inc(input logic [7:0] v, input logic [7:0] last, first);
        if (v == last) return first;
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction
    function automatic btc_time_t step(input btc_time_t t);
        btc_time_t n;
        logic [7:0] dm;
        n = t;
        dm = (t.month == 8'h02) ? (((t.year[7:4] * 10 + t.year[3:0]) % 4 == 0) ? 8'h29 : 8'h28)
            : (t.month inside {8'h04, 8'h06, 8'h09, 8'h11}) ? 8'h30 : 8'h31;
        n.sec = inc(t.sec, 8'h59, 8'h00);
        if (t.sec == 8'h59) n.min = inc(t.min, 8'h59, 8'h00);
        if (t.sec == 8'h59 && t.min == 8'h59) begin
            n.hour = inc(t.hour, 8'h23, 8'h00);
            if (t.hour == 8'h23) begin
                n.week = (t.week == 8'h40) ? 8'h01 : t.week << 1;
                n.date = inc(t.date, dm, 8'h01);
                if (t.date == dm) n.month = inc(t.month, 8'h12, 8'h01);
                if (t.date == dm && t.month == 8'h12) n.year = inc(t.year, 8'h99, 8'h00);
            end
        end
        return n;
    endfunction
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_ev();
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (update_event === 1'b1) break;
        end
        if (i == 400) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        host.acc(1'b0, a, 8'h00);
        #1;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        exp = {RST_SEC, RST_MIN, RST_HOUR, RST_WEEK, RST_DATE, RST_MONTH, RST_YEAR};
        `CHK("reset", exp, time_out)
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            upd_sel = (i >= 6);
            row = rows[i];
            if (upd_sel) row.sec = {1'b0, 3'(xs() % 6), 4'(xs() % 10)};
            host.acc(1'b1, ADDR_EXT | mir(), {2'b00, upd_sel, 5'h00});
            // Bit 7 on the seconds write must be dropped by the fixed-zero mask
            for (int k = 0; k < 7; k++) begin
                wbyte = row[55 - 8 * k -: 8] | ((k == 0) ? 8'h80 : 8'h00);
                host.acc(1'b1, 5'(k) | mir(), wbyte);
            end
            j = xs() % 7;
            rd(5'(j) | mir(), row[55 - 8 * j -: 8]);
            rd(ADDR_EXT | mir(), {2'b00, upd_sel, 5'h00});
            rd(5'h07, 8'h00);
            host.idle();
            exp = row;
            repeat (3) begin
                wait_ev();
                exp = step(exp);
                while (upd_sel && exp.sec !== 8'h00) exp = step(exp);
                `CHK("time", exp, time_out)
            end
        end
        conclude();
    end
endmodule
